// ### design/touch_debug_consts.svh
`ifndef TOUCH_DEBUG_CONSTS_SVH
`define TOUCH_DEBUG_CONSTS_SVH

// Timing
`define TDF_CLK_HZ 25000000
`define TDF_BAUD 115200
`define TDF_BIT_CYC (`TDF_CLK_HZ / `TDF_BAUD)

// Frame layout
`define TDF_LAST_BYTE 7'h6A
`define TDF_LEAD0 8'h0D
`define TDF_LEAD1 8'h0A
`define TDF_MARKER 8'h80
`define TDF_TAG_A 8'h01
`define TDF_TAG_B 8'h02
`define TDF_TAIL 8'hFF
`define TDF_CP_LIMIT 8'h28
`define TDF_RANGE_BAD 2'h3

// Register offsets (byte addresses)
`define TDF_CTRL 8'h00
`define TDF_STAT 8'h04
`define TDF_INFO 8'h08
`define TDF_STATE 8'h0C
`define TDF_SHORT 8'h10
`define TDF_XSHORT 8'h14
`define TDF_SNR_A 8'h18
`define TDF_SNR_B 8'h1C
`define TDF_CH_BASE 8'h20
`define TDF_CH_LAST 8'h6F

// Writable bit masks and reset values
`define TDF_CTRL_MASK 32'h0000_0001
`define TDF_CTRL_RST 32'h0000_0001
`define TDF_INFO_MASK 32'h0003_FFFF
`define TDF_PAIR_MASK 32'h03FF_03FF
`define TDF_XS_MASK 32'h0000_03FF
`define TDF_SNRB_MASK 32'h0000_00FF
`define TDF_CHB_MASK 32'h00FF_FFFF

`define TDF_RESP_OK 2'h0
`define TDF_RESP_ERR 2'h2

`endif

// ### design/touch_debug_frame_tx.sv
// Overview of operation
// - Enabled debug output sends sensing data serially
// - Bytes go out near 115200 baud
// - Strap at debug pin gates the transmitter
// - Frame opens 0x0D, 0x0A, 0x80, firmware_version
// - Bytes 4-5 hold capacitance of channels 0-1
// - Bytes 6-25 raw counts, high byte first
// - Bytes 26-31 capacitance, zeros and SNR pairs
// - Bytes 32-33 supply-short flags, then 0x00, 0x01
// - Bytes 36-39 zero, touch high, zero, touch low
// - Bytes 40-59 baselines, high byte first
// - Bytes 60-65 capacitance, SNR, zero, SNR
// - Ground flags, 0x00, 0x02, compensated_current_setting
// - Bytes 71-73 output state high, zero, low
// - Bytes 74-93 delta counts, high byte first
// - Bytes 94-98 capacitance, one SNR byte, zero
// - Range code, cross-short then high-capacitance flags
// - Frame closes 0x00, 0xFF, 0xFF
// - Low byte channels 0-7, high bits 8-9
// - Short flag bit set when fault found
// - High-capacitance bit set above 40 pF
// - Range code 0 in range, 1 high, 2 low
// - Diagnostic flags come from power-on self check
//
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "touch_debug_consts.svh"

module touch_debug_frame_tx (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic scan_done,
	input wire logic debug_strap,
	output logic debug_tx,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready
);
	localparam int BIT_M1 = `TDF_BIT_CYC - 1;

	touch_debug_pkg::tx_state_e state_r;
	touch_debug_pkg::byte_t cur_byte;
	touch_debug_pkg::byte_t shift_r;
	logic [7:0] baud_r;
	logic [2:0] bit_r;
	logic [6:0] byte_idx_r;
	logic [7:0] frame_cnt_r;
	logic tx_r, pending_r, strap_sel_r, strap_taken_r, diag_lock_r;
	logic bit_end, last_byte, frame_start, enable, busy, shift_lsb;

	logic aw_got_r, w_got_r, bvalid_r, rvalid_r;
	logic [7:0] wa_r;
	logic [31:0] wd_r;
	logic [3:0] ws_r;
	logic [1:0] bresp_r, rresp_r;
	logic [31:0] rdata_r;
	logic do_wr, wr_ok;
	logic [31:0] rd_nxt;
	logic rd_ok;

	logic [31:0] ctrl_r, info_r, state_bits_r, short_r, xshort_r, snra_r, snrb_r;
	logic [31:0] chan_a_r [10];
	logic [31:0] chan_b_r [10];
	logic [9:0] hicap;
	logic [7:0] wofs, rofs;
	logic [31:0] info_m;

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s, input logic [31:0] m);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[i*8 +: 8] = n[i*8 +: 8];
			end
		end
		return r & m;
	endfunction : merge

	function automatic logic [7:0] hi_flags(input logic [9:0] f);
		return {6'h00, f[9:8]};
	endfunction : hi_flags

	// Strap caught once after reset release
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			strap_taken_r <= 1'b0;
			strap_sel_r <= 1'b0;
		end else if (!strap_taken_r) begin
			strap_taken_r <= 1'b1;
			strap_sel_r <= debug_strap;
		end
	end

	assign enable = ctrl_r[0] && strap_sel_r;
	assign busy = state_r != touch_debug_pkg::TX_IDLE;

	// AXI4-Lite write channel
	assign awready = !aw_got_r && !bvalid_r;
	assign wready = !w_got_r && !bvalid_r;
	assign do_wr = aw_got_r && w_got_r;
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;
	assign wofs = wa_r - `TDF_CH_BASE;

	always_comb begin
		wr_ok = 1'b1;
		unique case (wa_r[7:2])
			`TDF_CTRL >> 2, `TDF_INFO >> 2, `TDF_STATE >> 2, `TDF_SNR_A >> 2,
				`TDF_SNR_B >> 2, `TDF_SHORT >> 2, `TDF_XSHORT >> 2: wr_ok = 1'b1;
			default: wr_ok = (wa_r >= `TDF_CH_BASE) && (wa_r <= `TDF_CH_LAST);
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			wa_r <= 8'h00;
			wd_r <= 32'h0000_0000;
			ws_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= `TDF_RESP_OK;
		end else begin
			if (awvalid && awready) begin
				aw_got_r <= 1'b1;
				wa_r <= awaddr;
			end
			if (wvalid && wready) begin
				w_got_r <= 1'b1;
				wd_r <= wdata;
				ws_r <= wstrb;
			end
			if (do_wr) begin
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= wr_ok ? `TDF_RESP_OK : `TDF_RESP_ERR;
			end else if (bvalid_r && bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	assign info_m = merge(info_r, wd_r, ws_r, `TDF_INFO_MASK);

	// Frame content registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r <= `TDF_CTRL_RST;
			info_r <= 32'h0000_0000;
			state_bits_r <= 32'h0000_0000;
			short_r <= 32'h0000_0000;
			xshort_r <= 32'h0000_0000;
			snra_r <= 32'h0000_0000;
			snrb_r <= 32'h0000_0000;
		end else if (do_wr) begin
			unique case ({wa_r[7:2], 2'h0})
				`TDF_CTRL: ctrl_r <= merge(ctrl_r, wd_r, ws_r, `TDF_CTRL_MASK);
				`TDF_INFO: begin
					info_r[15:0] <= info_m[15:0];
					if (!diag_lock_r && info_m[17:16] != `TDF_RANGE_BAD) begin
						info_r[17:16] <= info_m[17:16];
					end
				end
				`TDF_STATE: state_bits_r <= merge(state_bits_r, wd_r, ws_r, `TDF_PAIR_MASK);
				`TDF_SHORT: begin
					if (!diag_lock_r) begin
						short_r <= merge(short_r, wd_r, ws_r, `TDF_PAIR_MASK);
					end
				end
				`TDF_XSHORT: begin
					if (!diag_lock_r) begin
						xshort_r <= merge(xshort_r, wd_r, ws_r, `TDF_XS_MASK);
					end
				end
				`TDF_SNR_A: snra_r <= merge(snra_r, wd_r, ws_r, 32'hFFFF_FFFF);
				`TDF_SNR_B: snrb_r <= merge(snrb_r, wd_r, ws_r, `TDF_SNRB_MASK);
				default: ;
			endcase
		end
	end

	for (genvar n = 0; n < 10; n++) begin : g_chan
		always_ff @(posedge core_clk or negedge rst_n) begin
			if (!rst_n) begin
				chan_a_r[n] <= 32'h0000_0000;
				chan_b_r[n] <= 32'h0000_0000;
			end else if (do_wr && wr_ok && wa_r >= `TDF_CH_BASE && wofs[6:3] == 4'(n)) begin
				if (!wofs[2]) begin
					chan_a_r[n] <= merge(chan_a_r[n], wd_r, ws_r, 32'hFFFF_FFFF);
				end else begin
					chan_b_r[n] <= merge(chan_b_r[n], wd_r, ws_r, `TDF_CHB_MASK);
				end
			end
		end
		assign hicap[n] = chan_b_r[n][23:16] > `TDF_CP_LIMIT;
	end

	// AXI4-Lite read channel
	assign arready = !rvalid_r;
	assign rvalid = rvalid_r;
	assign rdata = rdata_r;
	assign rresp = rresp_r;
	assign rofs = araddr - `TDF_CH_BASE;

	always_comb begin
		rd_nxt = 32'h0000_0000;
		rd_ok = 1'b1;
		unique case (araddr[7:2])
			`TDF_CTRL >> 2: rd_nxt = ctrl_r;
			`TDF_STAT >> 2: rd_nxt = {16'h0000, frame_cnt_r, 3'h0, diag_lock_r,
				strap_sel_r, enable, pending_r, busy};
			`TDF_INFO >> 2: rd_nxt = info_r;
			`TDF_STATE >> 2: rd_nxt = state_bits_r;
			`TDF_SHORT >> 2: rd_nxt = short_r;
			`TDF_XSHORT >> 2: rd_nxt = {6'h00, hicap, xshort_r[15:0]};
			`TDF_SNR_A >> 2: rd_nxt = snra_r;
			`TDF_SNR_B >> 2: rd_nxt = snrb_r;
			default: begin
				if (araddr >= `TDF_CH_BASE && araddr <= `TDF_CH_LAST) begin
					rd_nxt = rofs[2] ? chan_b_r[rofs[6:3]] : chan_a_r[rofs[6:3]];
				end else begin
					rd_ok = 1'b0;
				end
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= `TDF_RESP_OK;
		end else if (arvalid && arready) begin
			rvalid_r <= 1'b1;
			rdata_r <= rd_nxt;
			rresp_r <= rd_ok ? `TDF_RESP_OK : `TDF_RESP_ERR;
		end else if (rvalid_r && rready) begin
			rvalid_r <= 1'b0;
		end
	end

	// Frame byte selection
	always_comb begin
		logic [6:0] off;
		off = 7'h00;
		cur_byte = 8'h00;
		if (byte_idx_r >= 7'd6 && byte_idx_r <= 7'd25) begin
			off = byte_idx_r - 7'd6;
			cur_byte = off[0] ? chan_a_r[off[4:1]][7:0] : chan_a_r[off[4:1]][15:8];
		end else if (byte_idx_r >= 7'd40 && byte_idx_r <= 7'd59) begin
			off = byte_idx_r - 7'd40;
			cur_byte = off[0] ? chan_a_r[off[4:1]][23:16] : chan_a_r[off[4:1]][31:24];
		end else if (byte_idx_r >= 7'd74 && byte_idx_r <= 7'd93) begin
			off = byte_idx_r - 7'd74;
			cur_byte = off[0] ? chan_b_r[off[4:1]][7:0] : chan_b_r[off[4:1]][15:8];
		end else begin
			unique case (byte_idx_r)
				7'd0: cur_byte = `TDF_LEAD0;
				7'd1: cur_byte = `TDF_LEAD1;
				7'd2: cur_byte = `TDF_MARKER;
				7'd3: cur_byte = info_r[7:0];
				7'd4: cur_byte = chan_b_r[0][23:16];
				7'd5: cur_byte = chan_b_r[1][23:16];
				7'd26: cur_byte = chan_b_r[2][23:16];
				7'd27: cur_byte = chan_b_r[3][23:16];
				7'd29: cur_byte = snra_r[7:0];
				7'd31: cur_byte = snra_r[15:8];
				7'd32: cur_byte = hi_flags(short_r[9:0]);
				7'd33: cur_byte = short_r[7:0];
				7'd35: cur_byte = `TDF_TAG_A;
				7'd37: cur_byte = hi_flags(state_bits_r[9:0]);
				7'd39: cur_byte = state_bits_r[7:0];
				7'd60: cur_byte = chan_b_r[4][23:16];
				7'd61: cur_byte = chan_b_r[5][23:16];
				7'd62: cur_byte = chan_b_r[6][23:16];
				7'd63: cur_byte = snra_r[23:16];
				7'd65: cur_byte = snra_r[31:24];
				7'd66: cur_byte = hi_flags(short_r[25:16]);
				7'd67: cur_byte = short_r[23:16];
				7'd69: cur_byte = `TDF_TAG_B;
				7'd70: cur_byte = info_r[15:8];
				7'd71: cur_byte = hi_flags(state_bits_r[25:16]);
				7'd73: cur_byte = state_bits_r[23:16];
				7'd94: cur_byte = chan_b_r[7][23:16];
				7'd95: cur_byte = chan_b_r[8][23:16];
				7'd96: cur_byte = chan_b_r[9][23:16];
				7'd97: cur_byte = snrb_r[7:0];
				7'd99: cur_byte = {6'h00, info_r[17:16]};
				7'd100: cur_byte = hi_flags(xshort_r[9:0]);
				7'd101: cur_byte = xshort_r[7:0];
				7'd102: cur_byte = hi_flags(hicap);
				7'd103: cur_byte = hicap[7:0];
				7'd105, 7'd106: cur_byte = `TDF_TAIL;
				default: cur_byte = 8'h00;
			endcase
		end
	end

	// Serial byte engine
	assign bit_end = baud_r == 8'(BIT_M1);
	assign last_byte = byte_idx_r == `TDF_LAST_BYTE;
	assign frame_start = enable && (scan_done || pending_r) &&
		(state_r == touch_debug_pkg::TX_IDLE ||
		(state_r == touch_debug_pkg::TX_STOP && bit_end && last_byte));
	assign shift_lsb = shift_r[0];

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			baud_r <= 8'h00;
		end else if (state_r == touch_debug_pkg::TX_IDLE || bit_end) begin
			baud_r <= 8'h00;
		end else begin
			baud_r <= baud_r + 8'h01;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= touch_debug_pkg::TX_IDLE;
			bit_r <= 3'h0;
			byte_idx_r <= 7'h00;
			shift_r <= 8'h00;
			frame_cnt_r <= 8'h00;
		end else begin
			unique case (state_r)
				touch_debug_pkg::TX_IDLE: begin
					if (frame_start) begin
						state_r <= touch_debug_pkg::TX_START;
						byte_idx_r <= 7'h00;
					end
				end
				touch_debug_pkg::TX_START: begin
					if (bit_end) begin
						shift_r <= cur_byte;
						bit_r <= 3'h0;
						state_r <= touch_debug_pkg::TX_DATA;
					end
				end
				touch_debug_pkg::TX_DATA: begin
					if (bit_end) begin
						shift_r <= {1'b0, shift_r[7:1]};
						bit_r <= bit_r + 3'h1;
						if (bit_r == 3'h7) begin
							state_r <= touch_debug_pkg::TX_STOP;
						end
					end
				end
				touch_debug_pkg::TX_STOP: begin
					if (bit_end) begin
						if (!last_byte) begin
							byte_idx_r <= byte_idx_r + 7'h01;
							state_r <= touch_debug_pkg::TX_START;
						end else begin
							frame_cnt_r <= frame_cnt_r + 8'h01;
							byte_idx_r <= 7'h00;
							state_r <= frame_start ? touch_debug_pkg::TX_START :
								touch_debug_pkg::TX_IDLE;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_r <= 1'b1;
		end else begin
			unique case (state_r)
				touch_debug_pkg::TX_START: tx_r <= 1'b0;
				touch_debug_pkg::TX_DATA: tx_r <= shift_lsb;
				default: tx_r <= 1'b1;
			endcase
		end
	end
	assign debug_tx = tx_r;

	// Scan during a frame waits, a new one wins over consume
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pending_r <= 1'b0;
		end else if (frame_start) begin
			pending_r <= pending_r && scan_done;
		end else begin
			pending_r <= pending_r || (scan_done && enable);
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			diag_lock_r <= 1'b0;
		end else if (frame_start) begin
			diag_lock_r <= 1'b1;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	a_idle_line: assert property (state_r == touch_debug_pkg::TX_IDLE |=> debug_tx)
		else $error("line not high while idle");
	a_start_low: assert property (state_r == touch_debug_pkg::TX_START |=> !debug_tx)
		else $error("start bit not low");
	a_data_order: assert property (state_r == touch_debug_pkg::TX_DATA |=>
		debug_tx == $past(shift_lsb))
		else $error("data bit not lsb first");
	a_bit_len: assert property (state_r == touch_debug_pkg::TX_START &&
		baud_r == 8'h00 |-> ##BIT_M1 state_r == touch_debug_pkg::TX_START ##1
		state_r == touch_debug_pkg::TX_DATA)
		else $error("start bit length wrong");
	a_lead_byte: assert property (state_r == touch_debug_pkg::TX_START && bit_end &&
		byte_idx_r == 7'h00 |=> shift_r == `TDF_LEAD0)
		else $error("frame lead byte wrong");
	a_tail_byte: assert property (state_r == touch_debug_pkg::TX_START && bit_end &&
		byte_idx_r == 7'd106 |=> shift_r == `TDF_TAIL)
		else $error("frame tail byte wrong");
	a_gate_start: assert property ($rose(busy) |-> $past(enable))
		else $error("frame started while disabled");
	a_frame_wrap: assert property (state_r == touch_debug_pkg::TX_STOP && bit_end &&
		last_byte |=> byte_idx_r == 7'h00 && $changed(frame_cnt_r))
		else $error("frame end not counted");
	a_range_code: assert property (info_r[17:16] != `TDF_RANGE_BAD)
		else $error("illegal range code");
	a_write_resp: assert property (do_wr |=> bvalid && !awready && !wready)
		else $error("write response missing");

	c_frame_done: cover property (state_r == touch_debug_pkg::TX_STOP && bit_end && last_byte);
	c_back_to_back: cover property (state_r == touch_debug_pkg::TX_STOP && frame_start);
	c_pending_set: cover property (busy && scan_done && enable);
	c_read_error: cover property (rvalid && rresp == `TDF_RESP_ERR);
endmodule : touch_debug_frame_tx

// ### design/touch_debug_pkg.sv
package touch_debug_pkg;
	typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_e;
	typedef logic [7:0] byte_t;
endpackage : touch_debug_pkg

// ### tb/serial_rx_model.sv
`timescale 1ns/100ps
`include "touch_debug_consts.svh"

module serial_rx_model (
	input wire logic core_clk,
	input wire logic line,
	output logic [7:0] rx_byte,
	output logic rx_valid,
	output logic rx_ferr
);
	localparam int BIT_CYC = `TDF_BIT_CYC;
	logic [7:0] sh;

	initial begin
		rx_byte = 8'h00;
		rx_valid = 1'b0;
		rx_ferr = 1'b0;
		sh = 8'h00;
		forever begin
			@(negedge core_clk);
			if (line === 1'b0) begin
				// Centre of start bit
				repeat (BIT_CYC / 2) @(negedge core_clk);
				if (line !== 1'b0) rx_ferr = 1'b1;
				for (int i = 0; i < 8; i++) begin
					repeat (BIT_CYC) @(negedge core_clk);
					sh[i] = line;
				end
				repeat (BIT_CYC) @(negedge core_clk);
				if (line !== 1'b1) rx_ferr = 1'b1;
				rx_byte = sh;
				rx_valid = 1'b1;
				@(negedge core_clk);
				rx_valid = 1'b0;
			end
		end
	end
endmodule : serial_rx_model

// ### tb/touch_debug_frame_tx_tb_top.sv
`timescale 1ns/100ps
`include "touch_debug_consts.svh"

module touch_debug_frame_tx_tb_top;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic scan_done = 1'b0;
	logic debug_strap = 1'b0;
	logic debug_tx;
	logic [7:0] awaddr = 8'h00;
	logic awvalid = 1'b0;
	logic awready;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic wvalid = 1'b0;
	logic wready;
	logic [1:0] bresp;
	logic bvalid;
	logic bready = 1'b0;
	logic [7:0] araddr = 8'h00;
	logic arvalid = 1'b0;
	logic arready;
	logic [31:0] rdata;
	logic [1:0] rresp;
	logic rvalid;
	logic rready = 1'b0;
	logic [7:0] rx_byte;
	logic rx_valid;
	logic rx_ferr;
	logic [7:0] rxq[$];
	logic [31:0] w_info, w_state, w_short, w_xs, w_snra, w_snrb, rd;
	logic [31:0] ch_a[10];
	logic [31:0] ch_b[10];
	logic [1:0] rs;
	int n_mismatch = 0;
	int tests_run = 0;
	int cyc = 0;

	touch_debug_frame_tx touch_debug_frame_tx_inst (.core_clk(core_clk), .rst_n(rst_n),
		.scan_done(scan_done), .debug_strap(debug_strap), .debug_tx(debug_tx),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

	serial_rx_model serial_rx_model_inst (.core_clk(core_clk), .line(debug_tx),
		.rx_byte(rx_byte), .rx_valid(rx_valid), .rx_ferr(rx_ferr));

	always #20 core_clk = ~core_clk;

	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (rx_valid === 1'b1) rxq.push_back(rx_byte);
		if (cyc == 260000) begin
			n_mismatch++;
			final_report();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic final_report();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : final_report

	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic at, wt, ad, wd;
		ad = 1'b0;
		wd = 1'b0;
		@(posedge core_clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(ad && wd)) begin
			@(negedge core_clk);
			at = awvalid && awready;
			wt = wvalid && wready;
			@(posedge core_clk);
			if (at) begin
				awvalid <= 1'b0;
				ad = 1'b1;
			end
			if (wt) begin
				wvalid <= 1'b0;
				wd = 1'b1;
			end
		end
		bready <= 1'b1;
		do @(negedge core_clk); while (bvalid !== 1'b1);
		r = bresp;
		@(posedge core_clk);
		bready <= 1'b0;
	endtask : axi_write

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'b1;
		do @(negedge core_clk); while (arready !== 1'b1);
		@(posedge core_clk);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(negedge core_clk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		@(posedge core_clk);
		rready <= 1'b0;
	endtask : axi_read

	task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		axi_write(a, d, r);
		check({30'h0, r}, 32'h0);
	endtask : wr_ok

	task automatic scan_pulse();
		@(posedge core_clk);
		scan_done <= 1'b1;
		@(posedge core_clk);
		scan_done <= 1'b0;
	endtask : scan_pulse

	task automatic do_reset(input logic strap);
		@(posedge core_clk);
		rst_n <= 1'b0;
		debug_strap <= strap;
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge core_clk);
		rxq.delete();
	endtask : do_reset

	function automatic logic [7:0] hi2(input logic [9:0] f);
		return {6'h00, f[9:8]};
	endfunction : hi2

	function automatic logic [7:0] exp_byte(input int i);
		logic [9:0] hc;
		for (int n = 0; n < 10; n++) hc[n] = ch_b[n][23:16] > 8'h28;
		if (i >= 6 && i <= 25) return i[0] ? ch_a[(i - 6) / 2][7:0] : ch_a[(i - 6) / 2][15:8];
		if (i >= 40 && i <= 59) return i[0] ? ch_a[(i - 40) / 2][23:16] : ch_a[(i - 40) / 2][31:24];
		if (i >= 74 && i <= 93) return i[0] ? ch_b[(i - 74) / 2][7:0] : ch_b[(i - 74) / 2][15:8];
		case (i)
			0: return 8'h0D;
			1: return 8'h0A;
			2: return 8'h80;
			3: return w_info[7:0];
			4, 5: return ch_b[i - 4][23:16];
			26, 27: return ch_b[i - 24][23:16];
			29: return w_snra[7:0];
			31: return w_snra[15:8];
			32: return hi2(w_short[9:0]);
			33: return w_short[7:0];
			35: return 8'h01;
			37: return hi2(w_state[9:0]);
			39: return w_state[7:0];
			60, 61, 62: return ch_b[i - 56][23:16];
			63: return w_snra[23:16];
			65: return w_snra[31:24];
			66: return hi2(w_short[25:16]);
			67: return w_short[23:16];
			69: return 8'h02;
			70: return w_info[15:8];
			71: return hi2(w_state[25:16]);
			73: return w_state[23:16];
			94, 95, 96: return ch_b[i - 87][23:16];
			97: return w_snrb[7:0];
			99: return {6'h00, w_info[17:16]};
			100: return hi2(w_xs[9:0]);
			101: return w_xs[7:0];
			102: return hi2(hc);
			103: return hc[7:0];
			105, 106: return 8'hFF;
			default: return 8'h00;
		endcase
	endfunction : exp_byte

	initial begin
		void'($urandom(67));
		do_reset(1'b0);
		scan_pulse();
		repeat (600) @(posedge core_clk);
		check(32'(rxq.size()), 32'h0);
		check({31'h0, debug_tx}, 32'h1);
		$display("test strap_off done");
		do_reset(1'b1);
		axi_read(`TDF_CTRL, rd, rs);
		check(rd, 32'h1);
		w_info = {14'h0, 2'($urandom % 3), 16'($urandom)};
		w_state = $urandom & `TDF_PAIR_MASK;
		w_short = $urandom & `TDF_PAIR_MASK;
		w_xs = $urandom & `TDF_XS_MASK;
		w_snra = $urandom;
		w_snrb = $urandom & `TDF_SNRB_MASK;
		wr_ok(`TDF_INFO, w_info);
		wr_ok(`TDF_STATE, w_state);
		wr_ok(`TDF_SHORT, w_short);
		wr_ok(`TDF_XSHORT, w_xs);
		wr_ok(`TDF_SNR_A, w_snra);
		wr_ok(`TDF_SNR_B, w_snrb);
		for (int n = 0; n < 10; n++) begin
			ch_a[n] = $urandom;
			ch_b[n] = $urandom & `TDF_CHB_MASK;
			ch_b[n][23:16] = (n == 0) ? 8'h28 : ((n == 1) ? 8'h29 : 8'($urandom % 81));
			wr_ok(8'h20 + 8'(8 * n), ch_a[n]);
			wr_ok(8'h24 + 8'(8 * n), ch_b[n]);
		end
		wr_ok(`TDF_INFO, {14'h0, 2'h3, w_info[15:0]});
		axi_read(`TDF_INFO, rd, rs);
		check(rd, w_info);
		axi_write(8'h70, 32'hFFFF_FFFF, rs);
		check({30'h0, rs}, 32'h2);
		axi_write(`TDF_STAT, 32'hFFFF_FFFF, rs);
		check({30'h0, rs}, 32'h2);
		axi_read(8'h70, rd, rs);
		check({rd[29:0], rs}, 32'h2);
		$display("test registers done");
		wr_ok(`TDF_CTRL, 32'h0);
		scan_pulse();
		repeat (600) @(posedge core_clk);
		check(32'(rxq.size()), 32'h0);
		$display("test disabled done");
		wr_ok(`TDF_CTRL, 32'h1);
		scan_pulse();
		repeat (300) @(posedge core_clk);
		scan_pulse();
		while (rxq.size() < 108) @(posedge core_clk);
		for (int i = 0; i < 107; i++) begin
			check({24'h0, rxq[i]}, {24'h0, exp_byte(i)});
		end
		check({24'h0, rxq[107]}, 32'h0D);
		check({31'h0, rx_ferr}, 32'h0);
		$display("test frame done");
		// Self-check results stay frozen once a frame has gone out
		wr_ok(`TDF_SHORT, ~w_short);
		axi_read(`TDF_SHORT, rd, rs);
		check(rd, w_short);
		$display("test diag lock done");
		final_report();
	end
endmodule : touch_debug_frame_tx_tb_top
